// File: odp_pkg.sv
// Package with register map, field layout, reset values and encodings for the output channel divider pair.
// Behaviour
// - Channel A polarity picks pin polarities: 00 pos/neg, 01 pos/pos, 10 neg/pos, 11 neg/neg; 00 at reset.
// - Each channel has a drive-boost bit selecting 3.5 mA LVDS drive when clear and 4.5 mA when set.
// - Each channel divider divides its input clock by the 10-bit programmed value plus one.
// - The 10-bit divide value sits as low eight bits in one register and upper two bits in bits 1:0 of the next.
// - After sync each divider starts after a 6-bit initial phase counted in half-periods of its input clock.
// - Both dividers run on the shared prescaler output clock and phase is measured against it.
// - Channel B config bit 7 selects the 3.3 V CMOS driver through ch_b_cmos33_en; the format field governs mode and pin enables either way.
// - Format codes: 000 off and tristate, 001 HSTL, 010 LVDS, 100 CMOS both, 101 CMOS P only, 110 CMOS N only.
// - Channel B polarity acts only in CMOS modes, with 00 pos/neg as default and 11 neg/neg.
// - A set sync-mask bit releases its divider from the static sync state and makes it ignore sync events.
// - Channel A format sits in bits 6:4 with the channel B encoding and resets to HSTL.
package odp_pkg;

  // ----------------------------------------
  // Register indices; byte address is four times the index.
  // ----------------------------------------
  localparam logic [11:0] ODP_IDX_SYNC_CTRL = 12'h426;
  localparam logic [11:0] ODP_IDX_A_CFG = 12'h427;
  localparam logic [11:0] ODP_IDX_A_DIV_LO = 12'h428;
  localparam logic [11:0] ODP_IDX_A_DIV_HI = 12'h429;
  localparam logic [11:0] ODP_IDX_A_PHASE = 12'h42a;
  localparam logic [11:0] ODP_IDX_B_CFG = 12'h42b;
  localparam logic [11:0] ODP_IDX_B_DIV_LO = 12'h42c;
  localparam logic [11:0] ODP_IDX_B_DIV_HI = 12'h42d;
  localparam logic [11:0] ODP_IDX_B_PHASE = 12'h42e;
  localparam logic [11:0] ODP_IDX_STATUS = 12'h42f;
  localparam int ODP_ADDR_W = 14;

  // ----------------------------------------
  // Field positions and reset values.
  // ----------------------------------------
  localparam int ODP_CFG_CMOS33_BIT = 7;
  localparam int ODP_CFG_FMT_HI = 6;
  localparam int ODP_CFG_FMT_LO = 4;
  localparam int ODP_CFG_POL_HI = 3;
  localparam int ODP_CFG_POL_LO = 2;
  localparam int ODP_CFG_BOOST_BIT = 1;
  localparam logic [7:0] ODP_A_CFG_RST = 8'h10;
  localparam logic [7:0] ODP_B_CFG_RST = 8'h00;
  localparam logic [7:0] ODP_A_CFG_MASK = 8'h7e;
  localparam logic [7:0] ODP_B_CFG_MASK = 8'hfe;
  localparam logic [7:0] ODP_DIV_HI_MASK = 8'h03;
  localparam logic [7:0] ODP_PHASE_MASK = 8'h3f;
  localparam logic [7:0] ODP_SYNC_MASK_MASK = 8'h03;
  localparam logic [7:0] ODP_REG_RST = 8'h00;

  // ----------------------------------------
  // Output formats, polarity codes and bus answers.
  // ----------------------------------------
  localparam logic [2:0] ODP_FMT_OFF = 3'h0;
  localparam logic [2:0] ODP_FMT_HSTL = 3'h1;
  localparam logic [2:0] ODP_FMT_LVDS = 3'h2;
  localparam logic [2:0] ODP_FMT_CMOS_PN = 3'h4;
  localparam logic [2:0] ODP_FMT_CMOS_P = 3'h5;
  localparam logic [2:0] ODP_FMT_CMOS_N = 3'h6;
  localparam logic [1:0] ODP_POL_PN = 2'h0;
  localparam logic [1:0] ODP_POL_PP = 2'h1;
  localparam logic [1:0] ODP_POL_NP = 2'h2;
  localparam logic [1:0] ODP_POL_NN = 2'h3;
  localparam logic [1:0] ODP_RESP_OKAY = 2'h0;
  localparam logic [1:0] ODP_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ODP_DIV_STATIC = 2'b00,
    ODP_DIV_DELAY = 2'b01,
    ODP_DIV_RUN = 2'b10
  } odp_div_state_e;

endpackage

// File: odp_chan_div.sv
// One channel divider producing two half-period output samples per prescaler clock.
`timescale 1ns/1ps
module odp_chan_div
  import odp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [9:0] div_val,
  input wire logic [5:0] phase_val,
  input wire logic sync_mask,
  input wire logic sync_pulse,
  output logic [1:0] half_out,
  output logic running,
  output logic delaying
);

  odp_div_state_e state_r, state_nxt;
  logic [11:0] half_r, half_nxt;
  logic [5:0] dly_r, dly_nxt;
  logic [1:0] out_r, out_nxt;
  logic [11:0] period_h;
  logic [11:0] high_h;

  assign high_h = {2'b00, div_val} + 12'h001;
  assign period_h = {high_h[10:0], 1'b0};

  // ----------------------------------------
  // Half-period stepping.
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    half_nxt = half_r;
    dly_nxt = dly_r;
    out_nxt = 2'b00;
    if (sync_mask) begin
      if (state_r == ODP_DIV_STATIC) begin
        state_nxt = ODP_DIV_RUN;
        half_nxt = 12'h000;
      end
    end else if (sync_pulse) begin
      half_nxt = 12'h000;
      dly_nxt = phase_val;
      state_nxt = (phase_val == 6'h00) ? ODP_DIV_RUN : ODP_DIV_DELAY;
    end
    // Bit 0 is the first half of the prescaler period, bit 1 the second.
    for (int i = 0; i < 2; i++) begin
      case (state_nxt)
        ODP_DIV_DELAY: begin
          out_nxt[i] = 1'b0;
          dly_nxt = dly_nxt - 6'h01;
          if (dly_nxt == 6'h00) begin
            state_nxt = ODP_DIV_RUN;
          end
        end
        ODP_DIV_RUN: begin
          out_nxt[i] = (half_nxt < high_h);
          // A ratio lowered mid-run wraps at once instead of counting through 4096 halves.
          half_nxt = (half_nxt + 12'h001 >= period_h) ? 12'h000 : half_nxt + 12'h001;
        end
        default: begin
          out_nxt[i] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ODP_DIV_STATIC;
      half_r <= 12'h000;
      dly_r <= 6'h00;
      out_r <= 2'b00;
    end else if (clk_en) begin
      state_r <= state_nxt;
      half_r <= half_nxt;
      dly_r <= dly_nxt;
      out_r <= out_nxt;
    end
  end

  assign half_out = out_r;
  assign running = (state_r == ODP_DIV_RUN);
  assign delaying = (state_r == ODP_DIV_DELAY);

endmodule

// File: odp_output_pair.sv
// Two output channels with dividers, pin formatting and an AXI4-Lite register slave.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module odp_output_pair
  import odp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic sync_event,
  input wire logic [13:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [1:0] ch_a_pin_p,
  output logic [1:0] ch_a_pin_n,
  output logic ch_a_pin_p_oe_n,
  output logic ch_a_pin_n_oe_n,
  output logic [2:0] ch_a_mode_select,
  output logic ch_a_drive_boost,
  output logic [1:0] ch_b_pin_p,
  output logic [1:0] ch_b_pin_n,
  output logic ch_b_pin_p_oe_n,
  output logic ch_b_pin_n_oe_n,
  output logic [2:0] ch_b_mode_select,
  output logic ch_b_drive_boost,
  output logic ch_b_cmos33_en
);

  // ----------------------------------------
  // Register file state.
  // ----------------------------------------
  logic [7:0] cfg_r [2];
  logic [7:0] cfg_nxt [2];
  logic [7:0] div_lo_r [2];
  logic [7:0] div_lo_nxt [2];
  logic [7:0] div_hi_r [2];
  logic [7:0] div_hi_nxt [2];
  logic [7:0] phase_r [2];
  logic [7:0] phase_nxt [2];
  logic [7:0] sync_ctrl_r, sync_ctrl_nxt;

  // ----------------------------------------
  // Bus handshake state.
  // ----------------------------------------
  logic aw_held_r, aw_held_nxt;
  logic w_held_r, w_held_nxt;
  logic [11:0] aw_idx_r, aw_idx_nxt;
  logic [7:0] wbyte_r, wbyte_nxt;
  logic wlane_r, wlane_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;

  logic [1:0] half_out [2];
  logic [1:0] div_run;
  logic [1:0] div_dly;

  function automatic logic idx_known(input logic [11:0] idx);
    idx_known = (idx >= ODP_IDX_SYNC_CTRL) && (idx <= ODP_IDX_STATUS);
  endfunction

  function automatic logic [7:0] read_reg(input logic [11:0] idx);
    case (idx)
      ODP_IDX_SYNC_CTRL: read_reg = sync_ctrl_r;
      ODP_IDX_A_CFG: read_reg = cfg_r[0];
      ODP_IDX_A_DIV_LO: read_reg = div_lo_r[0];
      ODP_IDX_A_DIV_HI: read_reg = div_hi_r[0];
      ODP_IDX_A_PHASE: read_reg = phase_r[0];
      ODP_IDX_B_CFG: read_reg = cfg_r[1];
      ODP_IDX_B_DIV_LO: read_reg = div_lo_r[1];
      ODP_IDX_B_DIV_HI: read_reg = div_hi_r[1];
      ODP_IDX_B_PHASE: read_reg = phase_r[1];
      ODP_IDX_STATUS: read_reg = {4'h0, div_dly, div_run};
      default: read_reg = 8'h00;
    endcase
  endfunction

  // ----------------------------------------
  // Bus slave next state.
  // ----------------------------------------
  always_comb begin
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    aw_idx_nxt = aw_idx_r;
    wbyte_nxt = wbyte_r;
    wlane_nxt = wlane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    sync_ctrl_nxt = sync_ctrl_r;
    for (int c = 0; c < 2; c++) begin
      cfg_nxt[c] = cfg_r[c];
      div_lo_nxt[c] = div_lo_r[c];
      div_hi_nxt[c] = div_hi_r[c];
      phase_nxt[c] = phase_r[c];
    end
    if (s_axi_awvalid && !aw_held_r) begin
      aw_held_nxt = 1'b1;
      aw_idx_nxt = s_axi_awaddr[13:2];
    end
    if (s_axi_wvalid && !w_held_r) begin
      w_held_nxt = 1'b1;
      wbyte_nxt = s_axi_wdata[7:0];
      wlane_nxt = s_axi_wstrb[0];
    end
    if (aw_held_r && w_held_r && !bvalid_r) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = idx_known(aw_idx_r) ? ODP_RESP_OKAY : ODP_RESP_SLVERR;
      if (wlane_r) begin
        case (aw_idx_r)
          ODP_IDX_SYNC_CTRL: sync_ctrl_nxt = wbyte_r & ODP_SYNC_MASK_MASK;
          ODP_IDX_A_CFG: cfg_nxt[0] = wbyte_r & ODP_A_CFG_MASK;
          ODP_IDX_A_DIV_LO: div_lo_nxt[0] = wbyte_r;
          ODP_IDX_A_DIV_HI: div_hi_nxt[0] = wbyte_r & ODP_DIV_HI_MASK;
          ODP_IDX_A_PHASE: phase_nxt[0] = wbyte_r & ODP_PHASE_MASK;
          ODP_IDX_B_CFG: cfg_nxt[1] = wbyte_r & ODP_B_CFG_MASK;
          ODP_IDX_B_DIV_LO: div_lo_nxt[1] = wbyte_r;
          ODP_IDX_B_DIV_HI: div_hi_nxt[1] = wbyte_r & ODP_DIV_HI_MASK;
          ODP_IDX_B_PHASE: phase_nxt[1] = wbyte_r & ODP_PHASE_MASK;
          default: begin
          end
        endcase
      end
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (rvalid_r) begin
      if (s_axi_rready) begin
        rvalid_nxt = 1'b0;
      end
    end else if (s_axi_arvalid) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = {24'h000000, read_reg(s_axi_araddr[13:2])};
      rresp_nxt = idx_known(s_axi_araddr[13:2]) ? ODP_RESP_OKAY : ODP_RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_idx_r <= 12'h000;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= ODP_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= ODP_RESP_OKAY;
      sync_ctrl_r <= ODP_REG_RST;
      cfg_r[0] <= ODP_A_CFG_RST;
      cfg_r[1] <= ODP_B_CFG_RST;
      for (int c = 0; c < 2; c++) begin
        div_lo_r[c] <= ODP_REG_RST;
        div_hi_r[c] <= ODP_REG_RST;
        phase_r[c] <= ODP_REG_RST;
      end
    end else if (clk_en) begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      aw_idx_r <= aw_idx_nxt;
      wbyte_r <= wbyte_nxt;
      wlane_r <= wlane_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      sync_ctrl_r <= sync_ctrl_nxt;
      for (int c = 0; c < 2; c++) begin
        cfg_r[c] <= cfg_nxt[c];
        div_lo_r[c] <= div_lo_nxt[c];
        div_hi_r[c] <= div_hi_nxt[c];
        phase_r[c] <= phase_nxt[c];
      end
    end
  end

  // A channel is held while its address or data is parked, which keeps one write in flight.
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready = !w_held_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ----------------------------------------
  // Channels: divider and pin formatting.
  // ----------------------------------------
  logic [1:0] pin_p_r [2];
  logic [1:0] pin_p_nxt [2];
  logic [1:0] pin_n_r [2];
  logic [1:0] pin_n_nxt [2];
  logic [1:0] p_oe_n_r, p_oe_n_nxt;
  logic [1:0] n_oe_n_r, n_oe_n_nxt;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_chan
      logic [2:0] fmt;
      logic [1:0] pol;
      logic is_cmos;

      odp_chan_div u_div (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .div_val({div_hi_r[g][1:0], div_lo_r[g]}),
        .phase_val(phase_r[g][5:0]),
        .sync_mask(sync_ctrl_r[g]),
        .sync_pulse(sync_event),
        .half_out(half_out[g]),
        .running(div_run[g]),
        .delaying(div_dly[g])
      );

      assign fmt = cfg_r[g][ODP_CFG_FMT_HI:ODP_CFG_FMT_LO];
      assign is_cmos = fmt[2] && (fmt != 3'h7);
      // channel B polarity only in CMOS
      assign pol = (g == 1 && !is_cmos) ? ODP_POL_PN : cfg_r[g][ODP_CFG_POL_HI:ODP_CFG_POL_LO];

      always_comb begin
        case (pol)
          ODP_POL_PP: begin
            pin_p_nxt[g] = half_out[g];
            pin_n_nxt[g] = half_out[g];
          end
          ODP_POL_NP: begin
            pin_p_nxt[g] = ~half_out[g];
            pin_n_nxt[g] = half_out[g];
          end
          ODP_POL_NN: begin
            pin_p_nxt[g] = ~half_out[g];
            pin_n_nxt[g] = ~half_out[g];
          end
          default: begin
            pin_p_nxt[g] = half_out[g];
            pin_n_nxt[g] = ~half_out[g];
          end
        endcase
        case (fmt)
          ODP_FMT_HSTL, ODP_FMT_LVDS, ODP_FMT_CMOS_PN: begin
            p_oe_n_nxt[g] = 1'b0;
            n_oe_n_nxt[g] = 1'b0;
          end
          ODP_FMT_CMOS_P: begin
            p_oe_n_nxt[g] = 1'b0;
            n_oe_n_nxt[g] = 1'b1;
          end
          ODP_FMT_CMOS_N: begin
            p_oe_n_nxt[g] = 1'b1;
            n_oe_n_nxt[g] = 1'b0;
          end
          default: begin
            p_oe_n_nxt[g] = 1'b1;
            n_oe_n_nxt[g] = 1'b1;
          end
        endcase
      end

      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          pin_p_r[g] <= 2'b00;
          pin_n_r[g] <= 2'b00;
          p_oe_n_r[g] <= 1'b1;
          n_oe_n_r[g] <= 1'b1;
        end else if (clk_en) begin
          pin_p_r[g] <= pin_p_nxt[g];
          pin_n_r[g] <= pin_n_nxt[g];
          p_oe_n_r[g] <= p_oe_n_nxt[g];
          n_oe_n_r[g] <= n_oe_n_nxt[g];
        end
      end
    end
  endgenerate

  assign ch_a_pin_p = pin_p_r[0];
  assign ch_a_pin_n = pin_n_r[0];
  assign ch_a_pin_p_oe_n = p_oe_n_r[0];
  assign ch_a_pin_n_oe_n = n_oe_n_r[0];
  assign ch_a_mode_select = cfg_r[0][ODP_CFG_FMT_HI:ODP_CFG_FMT_LO];
  assign ch_a_drive_boost = cfg_r[0][ODP_CFG_BOOST_BIT];
  assign ch_b_drive_boost = cfg_r[1][ODP_CFG_BOOST_BIT];
  assign ch_b_pin_p = pin_p_r[1];
  assign ch_b_pin_n = pin_n_r[1];
  assign ch_b_pin_p_oe_n = p_oe_n_r[1];
  assign ch_b_pin_n_oe_n = n_oe_n_r[1];
  assign ch_b_mode_select = cfg_r[1][ODP_CFG_FMT_HI:ODP_CFG_FMT_LO];
  assign ch_b_cmos33_en = cfg_r[1][ODP_CFG_CMOS33_BIT];

endmodule

// File: odp_output_pair_checker.sv
// Port-level assertions for the output channel divider pair.
`timescale 1ns/1ps
module odp_output_pair_checker
  import odp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic [2:0] ch_a_mode_select,
  input wire logic ch_a_drive_boost,
  input wire logic ch_b_pin_p_oe_n,
  input wire logic ch_b_pin_n_oe_n,
  input wire logic [2:0] ch_b_mode_select
);
  logic unmapped_r;
  logic unmapped_nxt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Decode of the read in flight
  // ----------------------------------------
  always_comb begin
    unmapped_nxt = unmapped_r;
    if (s_axi_arvalid && s_axi_arready && clk_en) begin
      unmapped_nxt = (s_axi_araddr[13:2] < ODP_IDX_SYNC_CTRL) || (s_axi_araddr[13:2] > ODP_IDX_STATUS);
    end
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      unmapped_r <= 1'b0;
    end else begin
      unmapped_r <= unmapped_nxt;
    end
  end
  reset_modes_a: assert property ($fell(sys_rst)
    |-> ch_a_mode_select == ODP_FMT_HSTL && ch_b_mode_select == ODP_FMT_OFF)
    else $error("mode outputs wrong after reset");
  b_off_tri_a: assert property (ch_b_mode_select == ODP_FMT_OFF && $stable(ch_b_mode_select)
    |-> ch_b_pin_p_oe_n && ch_b_pin_n_oe_n)
    else $error("channel b driven while powered down");
  b_p_only_a: assert property (ch_b_mode_select == ODP_FMT_CMOS_P && $stable(ch_b_mode_select)
    |-> !ch_b_pin_p_oe_n && ch_b_pin_n_oe_n)
    else $error("channel b p-only enables wrong");
  b_n_only_a: assert property (ch_b_mode_select == ODP_FMT_CMOS_N && $stable(ch_b_mode_select)
    |-> ch_b_pin_p_oe_n && !ch_b_pin_n_oe_n)
    else $error("channel b n-only enables wrong");
  boost_by_write_a: assert property ($changed(ch_a_drive_boost) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("boost changed without a write");
  b_mode_write_a: assert property ($changed(ch_b_mode_select) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("channel b mode changed without a write");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
    else $error("read answer late");
  read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while answer pending");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en
    |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer timing wrong");
  unmapped_err_a: assert property (s_axi_rvalid && unmapped_r
    |-> s_axi_rresp == ODP_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  cover_unmapped: cover property (s_axi_rvalid && unmapped_r);
  cover_p_only: cover property (ch_b_mode_select == ODP_FMT_CMOS_P);
  cover_boost: cover property ($rose(ch_a_drive_boost));
endmodule

bind odp_output_pair odp_output_pair_checker u_odp_output_pair_checker (
  .clk_sys, .sys_rst, .clk_en, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .ch_a_mode_select, .ch_a_drive_boost, .ch_b_pin_p_oe_n, .ch_b_pin_n_oe_n, .ch_b_mode_select
);

// File: odp_clk_receiver.sv
// Downstream clock receiver model that measures a two-sample-per-cycle pin stream.
`timescale 1ns/1ps
module odp_clk_receiver (
  input wire logic clk_sys,
  input wire logic arm,
  input wire logic [1:0] pin,
  output logic [15:0] first_rise,
  output logic [15:0] period,
  output logic [15:0] high_len,
  output logic [15:0] rises
);
  logic last = 1'b1;
  logic [15:0] half = '0;
  logic [15:0] last_rise = '0;
  // Arming treats the line as high so a stale level is never taken for an edge.
  always @(posedge clk_sys) begin
    if (arm) begin
      half = '0;
      rises = '0;
      first_rise = '1;
      last = 1'b1;
    end
    for (int i = 0; i < 2; i++) begin
      if (pin[i] && !last) begin
        if (rises == 16'h0) begin
          first_rise = half;
        end else begin
          period = half - last_rise;
        end
        last_rise = half;
        rises = rises + 16'h1;
      end
      if (!pin[i] && last && rises != 16'h0) begin
        high_len = half - last_rise;
      end
      last = pin[i];
      half = half + 16'h1;
    end
  end
endmodule

// File: odp_output_pair_bench.sv
// Self-checking bench for the output channel divider pair.
`timescale 1ns/1ps
module odp_output_pair_bench
  import odp_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic sync_event = 1'b0;
  logic arm = 1'b0;
  logic clk_en = 1'b1;
  logic [13:0] s_axi_awaddr = '0;
  logic [13:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [1:0] ch_a_pin_p, ch_a_pin_n, ch_b_pin_p, ch_b_pin_n;
  logic ch_a_pin_p_oe_n, ch_a_pin_n_oe_n, ch_b_pin_p_oe_n, ch_b_pin_n_oe_n;
  logic [2:0] ch_a_mode_select, ch_b_mode_select;
  logic ch_a_drive_boost, ch_b_drive_boost, ch_b_cmos33_en;
  logic [15:0] fr_a, per_a, hi_a, rs_a, fr_b, per_b, hi_b, rs_b;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;

  odp_output_pair u_odp_output_pair (
    .clk_sys, .sys_rst, .clk_en, .sync_event, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready(1'b1), .ch_a_pin_p, .ch_a_pin_n, .ch_a_pin_p_oe_n, .ch_a_pin_n_oe_n,
    .ch_a_mode_select, .ch_a_drive_boost, .ch_b_pin_p, .ch_b_pin_n, .ch_b_pin_p_oe_n, .ch_b_pin_n_oe_n,
    .ch_b_mode_select, .ch_b_drive_boost, .ch_b_cmos33_en
  );
  odp_clk_receiver u_rx_a (.clk_sys, .arm, .pin(ch_a_pin_p), .first_rise(fr_a), .period(per_a),
    .high_len(hi_a), .rises(rs_a));
  odp_clk_receiver u_rx_b (.clk_sys, .arm, .pin(ch_b_pin_p), .first_rise(fr_b), .period(per_b),
    .high_len(hi_b), .rises(rs_b));

  always #2 clk_sys = ~clk_sys;
  // The longest divide-by-1024 pass needs about 3200 cycles; the limit leaves ample margin.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      conclude();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: bus value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_sig(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: output or measure %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic axw(input logic [11:0] idx, input logic [7:0] d);
    bit a_ok;
    bit w_ok;
    a_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(a_ok && w_ok)) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) begin
        a_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    @(posedge clk_sys);
    while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
    chk_val({30'h0, s_axi_bresp}, {30'h0, ODP_RESP_OKAY});
  endtask
  task automatic axr(input logic [11:0] idx, input logic [7:0] exp, input logic [1:0] er);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    @(posedge clk_sys);
    while (s_axi_arready !== 1'b1) @(posedge clk_sys);
    s_axi_arvalid <= 1'b0;
    @(posedge clk_sys);
    while (s_axi_rvalid !== 1'b1) @(posedge clk_sys);
    chk_val(s_axi_rdata, {24'h0, exp});
    chk_val({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic setdiv(input logic [9:0] dv, input logic [5:0] pa, input logic [5:0] pb);
    axw(ODP_IDX_A_DIV_LO, dv[7:0]);
    axw(ODP_IDX_A_DIV_HI, {6'h0, dv[9:8]});
    axw(ODP_IDX_B_DIV_LO, dv[7:0]);
    axw(ODP_IDX_B_DIV_HI, {6'h0, dv[9:8]});
    axw(ODP_IDX_A_PHASE, {2'h0, pa});
    axw(ODP_IDX_B_PHASE, {2'h0, pb});
  endtask
  task automatic arm_rx();
    arm <= 1'b1;
    @(posedge clk_sys);
    arm <= 1'b0;
  endtask
  // Arming waits out the pipeline so the receivers only see the restarted stream.
  task automatic sync_go();
    sync_event <= 1'b1;
    @(posedge clk_sys);
    sync_event <= 1'b0;
    tick(2);
    arm_rx();
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [1:0] pol;
    logic [7:0] wv [8];
    logic [7:0] ev [8];
    logic [1:0] oe_tab [8];
    logic [9:0] dv_tab [3];
    logic [5:0] ph_tab [3];
    wv = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hcf, 8'hff, 8'hff, 8'hff};
    ev = '{8'h7e, 8'hff, 8'h03, 8'h3f, 8'hce, 8'hff, 8'h03, 8'h3f};
    oe_tab = '{2'b11, 2'b00, 2'b00, 2'b11, 2'b00, 2'b01, 2'b10, 2'b11};
    dv_tab = '{10'h000, 10'h002, 10'h3ff};
    ph_tab = '{6'h00, 6'h05, 6'h37};
    tick(12);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk_sig({13'h0, ch_a_mode_select}, {13'h0, ODP_FMT_HSTL});
    axr(ODP_IDX_A_CFG, ODP_A_CFG_RST, ODP_RESP_OKAY);
    for (int k = 1; k < 8; k++) begin
      axr(ODP_IDX_A_CFG + 12'(k), ODP_REG_RST, ODP_RESP_OKAY);
    end
    axr(12'h430, 8'h00, ODP_RESP_SLVERR);
    for (int k = 0; k < 4; k++) begin
      pol = k[1:0];
      axw(ODP_IDX_A_CFG, {2'b00, 2'b01, pol, 2'b00});
      tick(3);
      chk_sig({14'h0, ch_a_pin_p}, {14'h0, {2{pol[1]}}});
      chk_sig({14'h0, ch_a_pin_n}, {14'h0, {2{pol[1] ~^ pol[0]}}});
    end
    axw(ODP_IDX_B_CFG, 8'h2c);
    tick(3);
    chk_sig({12'h0, ch_b_pin_p, ch_b_pin_n}, 16'h0003);
    axw(ODP_IDX_B_CFG, 8'h4c);
    tick(3);
    chk_sig({12'h0, ch_b_pin_p, ch_b_pin_n}, 16'h000f);
    for (int k = 0; k < 8; k++) begin
      axw(ODP_IDX_A_CFG + 12'(k), wv[k]);
    end
    for (int k = 0; k < 8; k++) begin
      axr(ODP_IDX_A_CFG + 12'(k), ev[k], ODP_RESP_OKAY);
    end
    chk_sig({13'h0, ch_a_drive_boost, ch_b_drive_boost, ch_b_cmos33_en}, 16'h0007);
    chk_sig({14'h0, ch_a_pin_p_oe_n, ch_a_pin_n_oe_n}, 16'h0003);
    for (int k = 0; k < 8; k++) begin
      axw(ODP_IDX_B_CFG, {1'b0, k[2:0], 4'h0});
      tick(3);
      chk_sig({14'h0, ch_b_pin_p_oe_n, ch_b_pin_n_oe_n}, {14'h0, oe_tab[k]});
      chk_sig({12'h0, ch_b_mode_select, ch_b_cmos33_en}, {12'h0, k[2:0], 1'b0});
    end
    axw(ODP_IDX_STATUS, 8'hff);
    axr(ODP_IDX_STATUS, 8'h00, ODP_RESP_OKAY);
    setdiv(10'h003, 6'h3f, 6'h3f);
    arm_rx();
    axw(ODP_IDX_SYNC_CTRL, 8'h01);
    tick(30);
    chk_sig({15'h0, rs_a != 16'h0}, 16'h0001);
    chk_sig(rs_b, 16'h0000);
    chk_sig(per_a, 16'd8);
    clk_en <= 1'b0;
    tick(2);
    pol = ch_a_pin_p;
    tick(5);
    chk_sig({14'h0, ch_a_pin_p}, {14'h0, pol});
    clk_en <= 1'b1;
    axr(ODP_IDX_STATUS, 8'h01, ODP_RESP_OKAY);
    sync_go();
    axr(ODP_IDX_STATUS, 8'h09, ODP_RESP_OKAY);
    axw(ODP_IDX_SYNC_CTRL, 8'h00);
    axw(ODP_IDX_A_CFG, 8'h10);
    axw(ODP_IDX_B_CFG, 8'h10);
    for (int k = 0; k < 3; k++) begin
      setdiv(dv_tab[k], 6'h08, 6'h08 + ph_tab[k]);
      sync_go();
      tick(3 * int'(dv_tab[k]) + 60);
      chk_sig(per_a, ({6'h0, dv_tab[k]} + 16'h1) << 1);
      chk_sig(hi_a, {6'h0, dv_tab[k]} + 16'h1);
      chk_sig(per_b, per_a);
      chk_sig(fr_b - fr_a, {10'h0, ph_tab[k]});
    end
    conclude();
  end
endmodule
